// [bench/loop_tuning_config_regs_tb_top.sv]
// Self-checking bench for the loop tuning register bank
`timescale 1ns/10ps
module loop_tuning_config_regs_tb_top;
    import ltc_pkg::*;

    logic        sys_clk = 1'b0;
    logic        rst_b, tick, topo, ss, pmb, osc, busy, ce;
    logic [5:0]  ph_low;
    logic [7:0]  duty, nclamp, err_clamp, ff_gain;
    logic [2:0]  dpl;
    logic [9:0]  vcmd, vout;
    logic [6:0]  integ, prop;
    logic [18:0] ff_const;
    logic        ack, nack, ph_seq, fire;
    logic [47:0] rd_data, ffv, q;
    logic [1:0]  an;
    ltc_req_t    req;
    ltc_corr_t   corr;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cyc = 0;

    // Clock; run is short so a 2000-cycle ceiling only trips on a hang
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            print_verdict();
        end
    end

    ltc_regs i_dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .CE(ce), .REQ(req),
        .ACK(ack), .NACK(nack), .RD_DATA(rd_data), .LOOP_TICK(tick),
        .TOPO_RESONANT(topo), .PHASE_LOW(ph_low), .DUTY_NOW(duty),
        .DUTY_PARAM_LOW(dpl), .SOFTSTART(ss), .NORMAL_CLAMP(nclamp),
        .PMBUS_DOMAIN(pmb), .VOUT_COMMAND(vcmd), .OSC_PULSE_REQ(osc),
        .PULSE_BUSY(busy), .CORR(corr), .INTEG_GAIN(integ),
        .PROP_GAIN(prop), .FF_CONST(ff_const), .FF_GAIN(ff_gain),
        .ERR_CLAMP(err_clamp), .PHASE_SEQUENTIAL(ph_seq),
        .PULSE_FIRE(fire), .VOUT_TARGET(vout));

    ltc_host_model i_host (.SYS_CLK(sys_clk), .REQ(req), .ACK(ack),
        .NACK(nack), .RD_DATA(rd_data));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string nm, input logic [47:0] seen,
                         input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp=%0h seen=%0h", nm, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [7:0] c, input logic [47:0] d);
        i_host.xfer(1'b1, c, d, q, an);
        check("wr_ack", an, 2'b10);
    endtask : wr

    task automatic rd_chk(input logic [7:0] c, input logic [47:0] e,
                          input string nm);
        i_host.xfer(1'b0, c, 48'h0, q, an);
        check(nm, q, e);
    endtask : rd_chk

    // Registered outputs settle one edge after their inputs move
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask : step

    task automatic loop_tick();
        tick = 1'b1;
        step();
        tick = 1'b0;
        step();
        step();
    endtask : loop_tick

    // Pulse request arrives while busy; fires once busy drops if stored
    task automatic pulse(input logic exp);
        busy = 1'b1;
        osc  = 1'b1;
        step();
        check("fire_busy", fire, 1'b0);
        busy = 1'b0;
        osc  = 1'b0;
        step();
        check("fire_late", fire, exp);
        step();
        check("fire_once", fire, 1'b0);
    endtask : pulse

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_b, tick, ss, osc, busy, ph_low, duty} = '0;
        {topo, pmb, ce} = 3'h7;
        dpl    = 3'h2;
        nclamp = 8'h50;
        vcmd   = 10'h064;
        repeat (5) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        rd_chk(CMD_SHARE_GAINS, SHARE_RESET, "share_rst");
        rd_chk(CMD_FEED_FORWARD, FF_RESET, "ff_rst");
        wr(CMD_SHARE_GAINS, 48'hFFFF);
        rd_chk(CMD_SHARE_GAINS, 48'h3FFF, "share_mask");
        i_host.xfer(1'b1, 8'hF8, 48'h1, q, an);
        check("bad_code", an, 2'b01);
        rd_chk(8'hF8, 48'h0, "bad_read");
        // Resonant set-up with every feature on
        ffv = i_host.mk_ff(19'h5A5A5, 5'h03, 1'b1, 6'h01, 1'b1);
        wr(CMD_SHARE_GAINS, i_host.mk_share(1'b1, 7'h05));
        wr(CMD_FEED_FORWARD, ffv);
        wr(CMD_VOUT_TRIM, i_host.mk_trim(8'hFE));
        rd_chk(CMD_FEED_FORWARD, ffv, "ff_back");
        rd_chk(CMD_VOUT_TRIM, 48'hFE, "trim_back");
        loop_tick();
        check("integ", integ, 7'h05);
        check("prop", prop, 7'h00);
        check("ff_const", ff_const, 19'h5A5A5);
        check("ff_gain", ff_gain, 8'h01);
        check("seq", ph_seq, 1'b1);
        check("vout_trim", vout, 10'h062);
        // Threshold is 0x1A from both halves; strict compare
        ph_low = 6'h05;
        duty   = 8'h1B;
        step();
        check("start_inc", corr.start_delay_inc, 6'h05);
        check("width_off", corr.width_inc, 6'h00);
        duty = 8'h1A;
        step();
        check("start_thr", corr.start_delay_inc, 6'h00);
        ss = 1'b1;
        step();
        check("clamp_ss", err_clamp, 8'h7C);
        // Clock enable low must freeze the clamp although its input moved
        ce = 1'b0;
        ss = 1'b0;
        step();
        check("clamp_hold", err_clamp, 8'h7C);
        ce = 1'b1;
        step();
        check("clamp_norm", err_clamp, 8'h50);
        pmb = 1'b0;
        step();
        check("vout_other", vout, 10'h064);
        pmb  = 1'b1;
        vcmd = 10'h001;
        step();
        check("vout_floor", vout, 10'h000);
        pulse(1'b1);
        // Full bridge with memory and sequencing off
        topo = 1'b0;
        ffv = i_host.mk_ff(19'h5A5A5, 5'h03, 1'b0, 6'h00, 1'b0);
        wr(CMD_SHARE_GAINS, i_host.mk_share(1'b0, 7'h03));
        wr(CMD_FEED_FORWARD, ffv);
        loop_tick();
        check("prop_fb", prop, 7'h03);
        check("ff_const_fb", ff_const, 19'h0);
        check("shuffle", ph_seq, 1'b0);
        check("width_inc", corr.width_inc, 6'h05);
        check("start_fb", corr.start_delay_inc, 6'h00);
        ss = 1'b1;
        step();
        check("clamp_off", err_clamp, 8'h50);
        pulse(1'b0);
        print_verdict();
    end

endmodule : loop_tuning_config_regs_tb_top

// [bench/ltc_host_model.sv]
// Host-side model that issues register commands to the tuning bank
`timescale 1ns/10ps
module ltc_host_model
    import ltc_pkg::*;
(
    input  wire logic               SYS_CLK,
    output      ltc_pkg::ltc_req_t  REQ,
    input  wire logic               ACK,
    input  wire logic               NACK,
    input  wire logic [47:0]        RD_DATA
);

    // Idle bus until the first command
    initial REQ = '0;

    // ------------------------------------------------------------------
    // Command transfer
    // ------------------------------------------------------------------
    // Request holds for exactly one sampled edge; answer is read 1ns after
    // that same edge, once the registered reply has settled
    task automatic xfer(input logic w, input logic [7:0] c,
                        input logic [47:0] d, output logic [47:0] q,
                        output logic [1:0] an);
        @(posedge SYS_CLK);
        #1;
        REQ = '{wr: w, rd: !w, code: c, data: d};
        @(posedge SYS_CLK);
        #1;
        REQ = '0;
        q  = RD_DATA;
        an = {ACK, NACK};
    endtask : xfer

    // ------------------------------------------------------------------
    // Value builders
    // ------------------------------------------------------------------
    // Only the gain that suits the topology is nonzero
    function automatic logic [47:0] mk_share(input logic res,
                                             input logic [6:0] g);
        mk_share = res ? {34'h0, g, 7'h00} : {41'h0, g};
    endfunction : mk_share

    // Reserved enables forced on and loop gain kept at one
    function automatic logic [47:0] mk_ff(input logic [18:0] c,
        input logic [4:0] d, input logic o, input logic [5:0] cl,
        input logic m);
        mk_ff = '0;
        mk_ff[42:24] = c;
        mk_ff[23:19] = d;
        mk_ff[18]    = o;
        mk_ff[15:10] = cl;
        mk_ff[8]     = m;
        mk_ff[17:16] = 2'b11;
        mk_ff[9]     = 1'b1;
        mk_ff[7:0]   = 8'h01;
    endfunction : mk_ff

    // The bench leaves the PMBus domain for one check only, where the trim is bypassed
    function automatic logic [47:0] mk_trim(input logic [7:0] t);
        mk_trim = {40'h00_0000_0000, t};
    endfunction : mk_trim

endmodule : ltc_host_model

// [src/ltc_pkg.sv]
// Constants, field layouts and carrier types of the loop tuning registers
// Summary of operation
// - Resonant: lagging phase gets longer start delay
// - Full bridge: lagging phase gets wider pulse width
// - Integral gain bits 13:7, proportional 6:0
// - Feed-forward constant 42:24, used only when resonant
// - Start correction only above duty threshold
// - Soft-start clamp is 2mV times (63 - field)
// - Soft-start clamp replaces normal clamp only while ramping
// - Bit 18 picks sequential or shuffled phase order
// - Bit 8 stores extra pulse requests, fires later
// - Signed trim in VID steps added to setpoint
// - Trim applies only in the PMBus control domain
package ltc_pkg;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_SHARE_GAINS   = 8'hF7;
    localparam logic [7:0]  CMD_FEED_FORWARD  = 8'hF9;
    localparam logic [7:0]  CMD_VOUT_TRIM     = 8'hFA;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          INTEG_HI          = 13;
    localparam int          INTEG_LO          = 7;
    localparam int          PROP_HI           = 6;
    localparam int          PROP_LO           = 0;
    localparam int          FF_CONST_HI       = 42;
    localparam int          FF_CONST_LO       = 24;
    localparam int          DUTY_HI           = 23;
    localparam int          DUTY_LO           = 19;
    localparam int          PH_ORDER_BIT      = 18;
    localparam int          SS_CLAMP_HI       = 15;
    localparam int          SS_CLAMP_LO       = 10;
    localparam int          PULSE_MEM_BIT     = 8;
    localparam int          FF_GAIN_HI        = 7;
    localparam int          FF_GAIN_LO        = 0;

    // Implemented bits of the share and feed-forward registers; the rest read as zero
    localparam logic [15:0] SHARE_MASK        = 16'h3FFF;
    localparam logic [47:0] FF_MASK           = 48'h07FF_FFFF_FFFF;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] SHARE_RESET       = 16'h0000;
    localparam logic [47:0] FF_RESET          = 48'h0000_0003_0201;
    localparam logic [7:0]  TRIM_RESET        = 8'h00;

    // ------------------------------------------------------------------
    // Derived numbers
    // ------------------------------------------------------------------
    localparam int          PHASES            = 6;
    localparam logic [7:0]  SS_CLAMP_BASE     = 8'h3F;
    localparam logic [3:0]  PEND_MAX          = 4'hF;
    localparam logic [11:0] VID_MAX           = 12'h3FF;

    // Host command from the PMBus front end
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [47:0] data;
    } ltc_req_t;

    // Per-phase share corrections handed to the modulator
    typedef struct packed {
        logic [PHASES-1:0] start_delay_inc;
        logic [PHASES-1:0] width_inc;
    } ltc_corr_t;

endpackage : ltc_pkg

// [src/ltc_regs.sv]
// Loop tuning register bank with its share, clamp, pulse and trim logic
`timescale 1ns/10ps
module ltc_regs (
    input  wire logic               SYS_CLK,
    input  wire logic               RST_B,
    input  wire logic               CE,
    input  wire ltc_pkg::ltc_req_t  REQ,
    output      logic               ACK,
    output      logic               NACK,
    output      logic [47:0]        RD_DATA,
    input  wire logic               LOOP_TICK,
    input  wire logic               TOPO_RESONANT,
    input  wire logic [5:0]         PHASE_LOW,
    input  wire logic [7:0]         DUTY_NOW,
    input  wire logic [2:0]         DUTY_PARAM_LOW,
    input  wire logic               SOFTSTART,
    input  wire logic [7:0]         NORMAL_CLAMP,
    input  wire logic               PMBUS_DOMAIN,
    input  wire logic [9:0]         VOUT_COMMAND,
    input  wire logic               OSC_PULSE_REQ,
    input  wire logic               PULSE_BUSY,
    output      ltc_pkg::ltc_corr_t CORR,
    output      logic [6:0]         INTEG_GAIN,
    output      logic [6:0]         PROP_GAIN,
    output      logic [18:0]        FF_CONST,
    output      logic [7:0]         FF_GAIN,
    output      logic [7:0]         ERR_CLAMP,
    output      logic               PHASE_SEQUENTIAL,
    output      logic               PULSE_FIRE,
    output      logic [9:0]         VOUT_TARGET
);
    import ltc_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [15:0]  share_sh_r;     // Last written, shown on readback
    logic [47:0]  ff_sh_r;
    logic [7:0]   trim_sh_r;
    logic [15:0]  share_act_r;    // Copy the loop actually uses
    logic [47:0]  ff_act_r;
    logic [7:0]   trim_act_r;
    logic [3:0]   pend_r;
    logic [3:0]   pend_nxt;
    logic         fire_nxt;
    logic [7:0]   duty_thr;
    logic         duty_ok;
    logic [5:0]   ss_field;
    logic [7:0]   ss_clamp;
    logic signed [11:0] trim_sum;
    logic [PHASES-1:0] delay_nxt;  // Next start-delay flags, one a phase
    logic [PHASES-1:0] width_nxt;  // Next width flags, one a phase

    // Decode a command code into a known register
    function automatic logic code_known(input logic [7:0] c);
        code_known = (c == CMD_SHARE_GAINS) || (c == CMD_FEED_FORWARD) ||
                     (c == CMD_VOUT_TRIM);
    endfunction : code_known

    // ------------------------------------------------------------------
    // Host writes
    // ------------------------------------------------------------------
    // Reserved enable bits are stored as written; the device does not
    // force them, so a bad host value reads back unchanged
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            share_sh_r <= SHARE_RESET;
            ff_sh_r    <= FF_RESET;
            trim_sh_r  <= TRIM_RESET;
        end else if (CE && REQ.wr) begin
            case (REQ.code)
                CMD_SHARE_GAINS: begin
                    share_sh_r <= REQ.data[15:0] & SHARE_MASK;
                end
                CMD_FEED_FORWARD: begin
                    ff_sh_r <= REQ.data & FF_MASK;
                end
                CMD_VOUT_TRIM: begin
                    trim_sh_r <= REQ.data[7:0];
                end
                default: ;
            endcase
        end
    end

    // Readback and acknowledge; unknown codes are refused with NACK
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ACK     <= 1'b0;
            NACK    <= 1'b0;
            RD_DATA <= 48'h0000_0000_0000;
        end else if (CE) begin
            ACK  <= (REQ.wr || REQ.rd) && code_known(REQ.code);
            NACK <= (REQ.wr || REQ.rd) && !code_known(REQ.code);
            if (REQ.rd) begin
                case (REQ.code)
                    CMD_SHARE_GAINS: begin
                        RD_DATA <= {32'h0000_0000, share_sh_r};
                    end
                    CMD_FEED_FORWARD: begin
                        RD_DATA <= ff_sh_r;
                    end
                    CMD_VOUT_TRIM: begin
                        RD_DATA <= {40'h00_0000_0000, trim_sh_r};
                    end
                    default: begin
                        RD_DATA <= 48'h0000_0000_0000;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Loop update
    // ------------------------------------------------------------------
    // Values move to the loop only on its tick, so a half-written set of
    // gains never disturbs a running cycle
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            share_act_r <= SHARE_RESET;
            ff_act_r    <= FF_RESET;
            trim_act_r  <= TRIM_RESET;
        end else if (CE && LOOP_TICK) begin
            share_act_r <= share_sh_r;
            ff_act_r    <= ff_sh_r;
            trim_act_r  <= trim_sh_r;
        end
    end

    // ------------------------------------------------------------------
    // Current sharing corrections
    // ------------------------------------------------------------------
    // Full threshold joins the upper field and the separate low bits
    always_comb begin
        duty_thr = {ff_act_r[DUTY_HI:DUTY_LO], DUTY_PARAM_LOW};
        duty_ok  = (duty_thr != 8'h00) && (DUTY_NOW > duty_thr);
    end

    // One correction flag per phase, steered by topology
    genvar gp;
    generate
        for (gp = 0; gp < PHASES; gp++) begin : g_phase
            assign delay_nxt[gp] = TOPO_RESONANT && duty_ok &&
                (share_act_r[INTEG_HI:INTEG_LO] != 7'h00) &&
                PHASE_LOW[gp];
            assign width_nxt[gp] = !TOPO_RESONANT &&
                (share_act_r[PROP_HI:PROP_LO] != 7'h00) &&
                PHASE_LOW[gp];
        end
    endgenerate

    // One register for the whole output keeps it to a single driver
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CORR <= '0;
        end else if (CE) begin
            CORR.start_delay_inc <= delay_nxt;
            CORR.width_inc       <= width_nxt;
        end
    end

    // Gain and feed-forward outputs
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            INTEG_GAIN       <= 7'h00;
            PROP_GAIN        <= 7'h00;
            FF_CONST         <= 19'h00000;
            FF_GAIN          <= 8'h00;
            PHASE_SEQUENTIAL <= 1'b0;
        end else if (CE) begin
            INTEG_GAIN <= share_act_r[INTEG_HI:INTEG_LO];
            PROP_GAIN  <= share_act_r[PROP_HI:PROP_LO];
            // Constant means nothing to a full bridge, so it is held off
            FF_CONST   <= TOPO_RESONANT ?
                          ff_act_r[FF_CONST_HI:FF_CONST_LO] : 19'h00000;
            FF_GAIN    <= ff_act_r[FF_GAIN_HI:FF_GAIN_LO];
            PHASE_SEQUENTIAL <= ff_act_r[PH_ORDER_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Error clamp
    // ------------------------------------------------------------------
    always_comb begin
        ss_field = ff_act_r[SS_CLAMP_HI:SS_CLAMP_LO];
        ss_clamp = (SS_CLAMP_BASE - {2'b00, ss_field}) << 1;
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ERR_CLAMP <= 8'h00;
        end else if (CE) begin
            if (SOFTSTART && (ss_field != 6'h00)) begin
                ERR_CLAMP <= ss_clamp;
            end else begin
                ERR_CLAMP <= NORMAL_CLAMP;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pulse memory
    // ------------------------------------------------------------------
    // A fire is spaced by one cycle so the busy input can rise first;
    // the count saturates and extra requests beyond it are lost
    always_comb begin
        fire_nxt = !PULSE_BUSY && !PULSE_FIRE &&
                   ((pend_r != 4'h0) || OSC_PULSE_REQ);
        pend_nxt = pend_r;
        if (OSC_PULSE_REQ && ff_act_r[PULSE_MEM_BIT] &&
            (PULSE_BUSY || PULSE_FIRE || (pend_r != 4'h0)) &&
            (pend_r != PEND_MAX)) begin
            pend_nxt = pend_nxt + 4'h1;
        end
        if (fire_nxt && (pend_r != 4'h0)) begin
            pend_nxt = pend_nxt - 4'h1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pend_r     <= 4'h0;
            PULSE_FIRE <= 1'b0;
        end else if (CE) begin
            pend_r     <= pend_nxt;
            PULSE_FIRE <= fire_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Output voltage trim
    // ------------------------------------------------------------------
    // Saturate at the VID code range instead of wrapping round
    always_comb begin
        trim_sum = $signed({2'b00, VOUT_COMMAND}) +
                   $signed({{4{trim_act_r[7]}}, trim_act_r});
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            VOUT_TARGET <= 10'h000;
        end else if (CE) begin
            if (!PMBUS_DOMAIN) begin
                VOUT_TARGET <= VOUT_COMMAND;
            end else if (trim_sum < 0) begin
                VOUT_TARGET <= 10'h000;
            end else if (trim_sum > $signed(VID_MAX)) begin
                VOUT_TARGET <= 10'h3FF;
            end else begin
                VOUT_TARGET <= trim_sum[9:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    a_share_write: assert property (
        CE && REQ.wr && REQ.code == CMD_SHARE_GAINS
        |=> share_sh_r == ($past(REQ.data[15:0]) & SHARE_MASK))
        else $error("share gains not stored");
    a_tick_apply: assert property (CE && LOOP_TICK && !REQ.wr
        |=> share_act_r == share_sh_r && trim_act_r == trim_sh_r)
        else $error("loop copy not updated on tick");
    a_read_back: assert property (
        CE && REQ.rd && REQ.code == CMD_VOUT_TRIM
        |=> RD_DATA[7:0] == $past(trim_sh_r) && ACK)
        else $error("trim readback wrong");
    a_cmd_answer: assert property (CE && (REQ.wr || REQ.rd)
        |=> ACK != NACK)
        else $error("command not answered exactly once");
    a_delay_topo: assert property (CE && !TOPO_RESONANT
        |=> CORR.start_delay_inc == 6'h00)
        else $error("start delay corrected outside resonant mode");
    a_width_topo: assert property (CE && TOPO_RESONANT
        |=> CORR.width_inc == 6'h00)
        else $error("width corrected in resonant mode");
    a_duty_off: assert property (CE && duty_thr == 8'h00
        |=> CORR.start_delay_inc == 6'h00)
        else $error("correction with duty threshold off");
    a_ff_resonant: assert property (CE && !TOPO_RESONANT
        |=> FF_CONST == 19'h00000)
        else $error("feed-forward constant used in full bridge");
    a_clamp_normal: assert property (CE && !SOFTSTART
        |=> ERR_CLAMP == $past(NORMAL_CLAMP))
        else $error("override clamp outside soft-start");
    a_clamp_value: assert property (
        CE && SOFTSTART && ss_field == 6'h01
        |=> ERR_CLAMP == 8'h7C)
        else $error("soft-start clamp value wrong");
    a_order_bit: assert property (
        CE |=> PHASE_SEQUENTIAL == $past(ff_act_r[PH_ORDER_BIT]))
        else $error("phase order does not follow bit");
    a_fire_gap: assert property (CE && PULSE_FIRE |=> !PULSE_FIRE)
        else $error("pulse fired back to back");
    a_fire_busy: assert property (CE && PULSE_BUSY |=> !PULSE_FIRE)
        else $error("pulse fired while busy");
    a_mem_off: assert property (
        CE && !ff_act_r[PULSE_MEM_BIT] && pend_r == 4'h0
        |=> pend_r == 4'h0)
        else $error("pulse stored with memory off");
    a_trim_domain: assert property (CE && !PMBUS_DOMAIN
        |=> VOUT_TARGET == $past(VOUT_COMMAND))
        else $error("trim applied outside PMBus domain");

    c_pend_fire: cover property (pend_r != 4'h0 ##1 PULSE_FIRE);
    c_ss_override: cover property (SOFTSTART && ERR_CLAMP != NORMAL_CLAMP);
    c_trim_used: cover property (PMBUS_DOMAIN && VOUT_TARGET != VOUT_COMMAND);
    c_nack: cover property (NACK);

endmodule : ltc_regs
